// ==== hw/tfc_pkg.sv ====
// constants, field layouts and carriers for the framer control register pair
package tfc_pkg;

  // register offsets and values after reset
  localparam logic [7:0] TFC_RX_CTRL_OFS   = 8'h2C;
  localparam logic [7:0] TFC_TX_CTRL_OFS   = 8'h35;
  localparam logic [7:0] TFC_RX_CTRL_RST   = 8'h00;
  localparam logic [7:0] TFC_TX_CTRL_RST   = 8'h00;
  localparam logic [7:0] TFC_UNMAPPED_READ = 8'h00;

  // receive_control_two field positions
  localparam int TFC_RX_CODE_POS   = 7;
  localparam int TFC_RX_DWIDE_POS  = 5;
  localparam int TFC_RX_MODE_POS   = 4;
  localparam int TFC_RX_DIR_POS    = 3;
  localparam int TFC_RX_FSREP_POS  = 1;

  // transmit_control_one field positions
  localparam int TFC_TX_FPASS_POS  = 6;
  localparam int TFC_TX_CPASS_POS  = 5;
  localparam int TFC_TX_RBS_POS    = 4;
  localparam int TFC_TX_GSTUFF_POS = 3;
  localparam int TFC_TX_BLUE_POS   = 1;

  // byte values on the data paths
  localparam logic [7:0] TFC_IDLE_CODE  = 8'h7F;
  localparam logic [7:0] TFC_ALL_ONES   = 8'hFF;
  localparam logic [7:0] TFC_ZERO_BYTE  = 8'h00;
  localparam int         TFC_MW_LEN     = 8;
  localparam logic [7:0] TFC_MW_SEQ [TFC_MW_LEN] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
  // bit 7 of a channel byte, counting msb as bit 1
  localparam int         TFC_STUFF_BIT  = 1;
  localparam int         TFC_RBS_BIT    = 0;

  // sync pulse lengths in bit periods, stored as remaining count
  localparam logic [1:0] TFC_SYNC_SINGLE_CNT = 2'h0;
  localparam logic [1:0] TFC_SYNC_DOUBLE_CNT = 2'h1;

  typedef struct packed {
    logic code_choice;
    logic double_width;
    logic timing_mode;
    logic direction;
    logic fs_report;
  } tfc_rx_cfg_t;

  typedef struct packed {
    logic framing_pass;
    logic crc_pass;
    logic rbs_en;
    logic gstuff;
    logic blue;
  } tfc_tx_cfg_t;

  localparam tfc_rx_cfg_t TFC_RX_CFG_RST = '{default: 1'b0};
  localparam tfc_tx_cfg_t TFC_TX_CFG_RST = '{default: 1'b0};

  function automatic tfc_rx_cfg_t tfc_rx_unpack(input logic [7:0] r);
    tfc_rx_cfg_t c;
    c.code_choice  = r[TFC_RX_CODE_POS];
    c.double_width = r[TFC_RX_DWIDE_POS];
    c.timing_mode  = r[TFC_RX_MODE_POS];
    c.direction    = r[TFC_RX_DIR_POS];
    c.fs_report    = r[TFC_RX_FSREP_POS];
    return c;
  endfunction

  function automatic tfc_tx_cfg_t tfc_tx_unpack(input logic [7:0] r);
    tfc_tx_cfg_t c;
    c.framing_pass = r[TFC_TX_FPASS_POS];
    c.crc_pass     = r[TFC_TX_CPASS_POS];
    c.rbs_en       = r[TFC_TX_RBS_POS];
    c.gstuff       = r[TFC_TX_GSTUFF_POS];
    c.blue         = r[TFC_TX_BLUE_POS];
    return c;
  endfunction

endpackage

// ==== hw/tfc_code_gen.sv ====
// receive replacement code source: idle byte or milliwatt sequence
module tfc_code_gen
  import tfc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       choice,
  input  wire logic       byte_tick,
  output logic [7:0]      code
);

  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [7:0] code_r;
  logic [7:0] code_nxt;

  always_comb begin
    idx_nxt  = idx_r;
    code_nxt = code_r;
    // sequence restarts from its first byte whenever the idle code is chosen
    if (!choice) begin
      idx_nxt  = 3'h0;
      code_nxt = TFC_IDLE_CODE; // [R1]
    end else if (byte_tick) begin
      code_nxt = TFC_MW_SEQ[idx_r]; // [R1]
      idx_nxt  = idx_r + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idx_r  <= 3'h0;
      code_r <= TFC_IDLE_CODE;
    end else begin
      idx_r  <= idx_nxt;
      code_r <= code_nxt;
    end
  end

  assign code = code_r;

  // check helper: no milliwatt byte sent since the idle code
  logic fresh_r;
  always_ff @(posedge clk) begin
    fresh_r <= rst || !choice || (fresh_r && !byte_tick);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_IDLE_CODE: assert property (!choice [*2] |-> code == TFC_IDLE_CODE) // [R1]
    else $error("idle code not presented");
  AST_MW_FIRST: assert property ((choice && byte_tick && fresh_r) |=> code == TFC_MW_SEQ[0]) // [R1]
    else $error("milliwatt sequence did not start at first byte");

endmodule // tfc_code_gen

// ==== hw/tfc_ctrl.sv ====
// receive control two and transmit control one register pair with the logic they steer
// Function
// [R1] The receive code choice bit selects the idle byte 7F hex when clear and the eight-byte milliwatt sequence when set.
// [R2] With the double width bit set the receive sync pulse lasts two bit periods in signaling frames, else one.
// [R3] Software keeps the double width bit zero while the sync timing mode bit or the sync direction bit is set.
// [R4] The sync timing mode bit makes the receive sync pulse mark frames when clear and multiframes when set.
// [R5] The sync direction bit drives the sync pin out when clear and makes it an input when set, valid only with the elastic store on.
// [R6] Software keeps the sync direction bit zero whenever the receive elastic store is disabled.
// [R7] The path violation counter counts Ft framing errors, and Fs framing errors as well when the report bit is set.
// [R8] Framing bits are generated inside when the framing pass-through bit is clear and passed through when set.
// [R9] CRC6 bits are sampled from the transmit serial input at F-bit time when the CRC pass-through bit is set, else computed inside.
// [R10] Robbed-bit signaling is inserted in no channel when disabled and in every non-transparent channel when enabled.
// [R11] Global stuffing forces bit 7 to one in every all-zero byte, else the transparency bits choose the stuffed channels.
// [R12] The blue alarm sends unframed all ones on both line outputs, else data goes out normally.
// [R13] Both registers read back the last written value and a new setting applies by the next frame boundary of its direction.
module tfc_ctrl
  import tfc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // host parallel port, synchronous to clk
  input  wire logic              host_wr_en,
  input  wire logic              host_rd_en,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [7:0]        host_wdata,
  output logic [7:0]             host_rdata,
  // receive side
  input  wire logic              rx_bit_tick,
  input  wire logic              rx_byte_tick,
  input  wire logic              rx_frame_start,
  input  wire logic              rx_multiframe_start,
  input  wire logic              rx_signaling_frame,
  input  wire logic              rx_elastic_store_enable,
  input  wire logic              ft_error,
  input  wire logic              fs_error,
  input  wire logic              receive_sync_pin_in,
  output logic                   receive_sync_pulse,
  output logic                   receive_sync_pulse_oe_n,
  output logic                   receive_sync_from_pin,
  output logic [7:0]             receive_code_choice_byte,
  output logic                   path_violation_counter_inc,
  // transmit side
  input  wire logic              tx_frame_start,
  input  wire logic              tx_byte_valid,
  input  wire logic [7:0]        tx_byte_in,
  input  wire logic              tx_chan_transparent,
  input  wire logic              tx_chan_stuff,
  input  wire logic              tx_signaling_frame,
  input  wire logic              tx_signaling_bit,
  input  wire logic              tx_fbit_valid,
  input  wire logic              tx_fbit_is_crc,
  input  wire logic              tx_fbit_internal,
  input  wire logic              tx_crc_internal,
  input  wire logic              tx_serial_data_in,
  input  wire logic              line_tick,
  input  wire logic              line_pos_in,
  input  wire logic              line_neg_in,
  output logic [7:0]             tx_byte_out,
  output logic                   tx_fbit_out,
  output logic                   line_out_positive,
  output logic                   line_out_negative
);

  if (ADDR_W < 6) begin : g_addr_chk
    $error("ADDR_W too narrow for the register offsets");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // host registers
  logic [7:0]  receive_control_two_r;
  logic [7:0]  receive_control_two_nxt;
  logic [7:0]  transmit_control_one_r;
  logic [7:0]  transmit_control_one_nxt;
  logic [7:0]  host_rdata_r;
  logic [7:0]  host_rdata_nxt;

  always_comb begin
    receive_control_two_nxt  = receive_control_two_r;
    transmit_control_one_nxt = transmit_control_one_r;
    host_rdata_nxt           = host_rdata_r;
    if (host_wr_en && hit(host_addr, TFC_RX_CTRL_OFS)) begin
      receive_control_two_nxt = host_wdata; // [R13]
    end
    if (host_wr_en && hit(host_addr, TFC_TX_CTRL_OFS)) begin
      transmit_control_one_nxt = host_wdata; // [R13]
    end
    if (host_rd_en) begin
      if (hit(host_addr, TFC_RX_CTRL_OFS)) begin
        host_rdata_nxt = receive_control_two_r; // [R13]
      end else if (hit(host_addr, TFC_TX_CTRL_OFS)) begin
        host_rdata_nxt = transmit_control_one_r; // [R13]
      end else begin
        host_rdata_nxt = TFC_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      receive_control_two_r  <= TFC_RX_CTRL_RST;
      transmit_control_one_r <= TFC_TX_CTRL_RST;
      host_rdata_r           <= TFC_UNMAPPED_READ;
    end else begin
      receive_control_two_r  <= receive_control_two_nxt;
      transmit_control_one_r <= transmit_control_one_nxt;
      host_rdata_r           <= host_rdata_nxt;
    end
  end

  assign host_rdata = host_rdata_r;

  // active settings, swapped at frame boundaries
  // a mid-frame write never splits a frame between two settings
  tfc_rx_cfg_t rx_cfg_r;
  tfc_rx_cfg_t rx_cfg_nxt;
  tfc_tx_cfg_t tx_cfg_r;
  tfc_tx_cfg_t tx_cfg_nxt;
  logic        rx_boundary;

  assign rx_boundary = rx_bit_tick && rx_frame_start;

  always_comb begin
    rx_cfg_nxt = rx_cfg_r;
    tx_cfg_nxt = tx_cfg_r;
    if (rx_boundary) begin
      rx_cfg_nxt = tfc_rx_unpack(receive_control_two_r); // [R13]
    end
    if (tx_frame_start) begin
      tx_cfg_nxt = tfc_tx_unpack(transmit_control_one_r); // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_cfg_r <= TFC_RX_CFG_RST;
      tx_cfg_r <= TFC_TX_CFG_RST;
    end else begin
      rx_cfg_r <= rx_cfg_nxt;
      tx_cfg_r <= tx_cfg_nxt;
    end
  end

  // receive sync pin
  logic       sync_meta_r;
  logic       sync_pin_r;
  logic       sync_pulse_r;
  logic       sync_pulse_nxt;
  logic [1:0] sync_cnt_r;
  logic [1:0] sync_cnt_nxt;
  logic       sync_oe_n_r;
  logic       sync_oe_n_nxt;
  logic       sync_start;
  logic       sync_input_mode;

  // pin input is honoured only while the elastic store runs; software is
  // expected to keep the direction bit clear otherwise
  assign sync_input_mode = rx_cfg_r.direction && rx_elastic_store_enable; // [R5] [R6]
  assign sync_start      = rx_bit_tick && rx_frame_start &&
                           (!rx_cfg_r.timing_mode || rx_multiframe_start); // [R4]

  always_comb begin
    sync_pulse_nxt = sync_pulse_r;
    sync_cnt_nxt   = sync_cnt_r;
    sync_oe_n_nxt  = sync_input_mode; // [R5]
    if (rx_bit_tick) begin
      if (sync_start) begin
        sync_pulse_nxt = 1'b1;
        // double width is meaningless in multiframe or input mode, relies on software
        sync_cnt_nxt   = (rx_cfg_r.double_width && rx_signaling_frame) ?
                         TFC_SYNC_DOUBLE_CNT : TFC_SYNC_SINGLE_CNT; // [R2] [R3]
      end else if (sync_cnt_r != 2'h0) begin
        sync_pulse_nxt = 1'b1;
        sync_cnt_nxt   = sync_cnt_r - 2'h1; // [R2]
      end else begin
        sync_pulse_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_meta_r  <= 1'b0;
      sync_pin_r   <= 1'b0;
      sync_pulse_r <= 1'b0;
      sync_cnt_r   <= 2'h0;
      sync_oe_n_r  <= 1'b0;
    end else begin
      sync_meta_r  <= receive_sync_pin_in;
      sync_pin_r   <= sync_meta_r;
      sync_pulse_r <= sync_pulse_nxt;
      sync_cnt_r   <= sync_cnt_nxt;
      sync_oe_n_r  <= sync_oe_n_nxt;
    end
  end

  assign receive_sync_pulse      = sync_pulse_r;
  assign receive_sync_pulse_oe_n = sync_oe_n_r;
  assign receive_sync_from_pin   = sync_pin_r;

  // replacement code and path violations
  logic pcv_r;
  logic pcv_nxt;

  tfc_code_gen u_code (
    .clk       (clk),
    .rst       (rst),
    .choice    (rx_cfg_r.code_choice),
    .byte_tick (rx_byte_tick),
    .code      (receive_code_choice_byte)
  );

  always_comb begin
    pcv_nxt = ft_error || (rx_cfg_r.fs_report && fs_error); // [R7]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pcv_r <= 1'b0;
    end else begin
      pcv_r <= pcv_nxt;
    end
  end

  assign path_violation_counter_inc = pcv_r;

  // transmit formatting
  logic [7:0] tx_byte_r;
  logic [7:0] tx_byte_nxt;
  logic       tx_fbit_r;
  logic       tx_fbit_nxt;
  logic       ser_meta_r;
  logic       ser_r;
  logic       pos_r;
  logic       pos_nxt;
  logic       neg_r;
  logic       neg_nxt;
  logic       mark_pol_r;
  logic       mark_pol_nxt;

  always_comb begin
    tx_byte_nxt  = tx_byte_r;
    tx_fbit_nxt  = tx_fbit_r;
    pos_nxt      = pos_r;
    neg_nxt      = neg_r;
    mark_pol_nxt = mark_pol_r;
    if (tx_byte_valid) begin
      tx_byte_nxt = tx_byte_in;
      if (tx_cfg_r.rbs_en && tx_signaling_frame && !tx_chan_transparent) begin
        tx_byte_nxt[TFC_RBS_BIT] = tx_signaling_bit; // [R10]
      end
      if (tx_byte_nxt == TFC_ZERO_BYTE && (tx_cfg_r.gstuff || tx_chan_stuff)) begin
        tx_byte_nxt[TFC_STUFF_BIT] = 1'b1; // [R11]
      end
      if (tx_cfg_r.blue) begin
        tx_byte_nxt = TFC_ALL_ONES; // [R12]
      end
    end
    if (tx_fbit_valid) begin
      if (tx_cfg_r.blue) begin
        tx_fbit_nxt = 1'b1; // [R12]
      end else if (tx_fbit_is_crc) begin
        tx_fbit_nxt = tx_cfg_r.crc_pass ? ser_r : tx_crc_internal; // [R9]
      end else begin
        tx_fbit_nxt = tx_cfg_r.framing_pass ? ser_r : tx_fbit_internal; // [R8]
      end
    end
    if (line_tick) begin
      if (tx_cfg_r.blue) begin
        // alternate mark inversion keeps the all-ones code free of violations
        pos_nxt      = !mark_pol_r; // [R12]
        neg_nxt      = mark_pol_r; // [R12]
        mark_pol_nxt = !mark_pol_r;
      end else begin
        pos_nxt = line_pos_in;
        neg_nxt = line_neg_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_byte_r  <= TFC_ZERO_BYTE;
      tx_fbit_r  <= 1'b0;
      ser_meta_r <= 1'b0;
      ser_r      <= 1'b0;
      pos_r      <= 1'b0;
      neg_r      <= 1'b0;
      mark_pol_r <= 1'b0;
    end else begin
      tx_byte_r  <= tx_byte_nxt;
      tx_fbit_r  <= tx_fbit_nxt;
      ser_meta_r <= tx_serial_data_in;
      ser_r      <= ser_meta_r;
      pos_r      <= pos_nxt;
      neg_r      <= neg_nxt;
      mark_pol_r <= mark_pol_nxt;
    end
  end

  assign tx_byte_out       = tx_byte_r;
  assign tx_fbit_out       = tx_fbit_r;
  assign line_out_positive = pos_r;
  assign line_out_negative = neg_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_READ_BACK: assert property ((host_wr_en && hit(host_addr, TFC_TX_CTRL_OFS)) ##1 // [R13]
    (host_rd_en && !host_wr_en && hit(host_addr, TFC_TX_CTRL_OFS)) |=> host_rdata == $past(host_wdata, 2))
    else $error("register read did not return last write");
  AST_CFG_APPLY: assert property (rx_boundary |=> rx_cfg_r == tfc_rx_unpack($past(receive_control_two_r))) // [R13]
    else $error("receive setting not applied at frame boundary");
  AST_SYNC_SINGLE: assert property ((sync_start && !(rx_cfg_r.double_width && rx_signaling_frame)) // [R2]
    |=> sync_pulse_r && sync_cnt_r == 2'h0)
    else $error("sync pulse not single width");
  AST_SYNC_DOUBLE: assert property ((sync_start && rx_cfg_r.double_width && rx_signaling_frame) // [R2]
    |=> sync_pulse_r && sync_cnt_r == 2'h1)
    else $error("sync pulse not double width");
  AST_SYNC_MF: assert property ((rx_bit_tick && rx_frame_start && !rx_multiframe_start && // [R4]
    rx_cfg_r.timing_mode && sync_cnt_r == 2'h0) |=> !sync_pulse_r)
    else $error("sync pulse outside multiframe boundary");
  AST_SYNC_DIR: assert property (!rx_elastic_store_enable [*2] |-> !receive_sync_pulse_oe_n) // [R5]
    else $error("sync pin released without elastic store");
  AST_PCV_FS: assert property ((fs_error && !ft_error && !rx_cfg_r.fs_report) |=> !pcv_r) // [R7]
    else $error("Fs error counted while not reported");
  AST_PCV_FT: assert property (ft_error |=> pcv_r) // [R7]
    else $error("Ft error not counted");
  AST_FRAMING: assert property ((tx_fbit_valid && !tx_fbit_is_crc && !tx_cfg_r.framing_pass && // [R8]
    !tx_cfg_r.blue) |=> tx_fbit_r == $past(tx_fbit_internal))
    else $error("internal framing bit not sent");
  AST_CRC_PASS: assert property ((tx_fbit_valid && tx_fbit_is_crc && tx_cfg_r.crc_pass && // [R9]
    !tx_cfg_r.blue) |=> tx_fbit_r == $past(ser_r))
    else $error("crc bit not taken from serial input");
  AST_RBS_OFF: assert property ((tx_byte_valid && !tx_cfg_r.rbs_en && !tx_cfg_r.blue && // [R10]
    tx_byte_in != TFC_ZERO_BYTE) |=> tx_byte_r == $past(tx_byte_in))
    else $error("byte altered with signaling disabled");
  AST_STUFF: assert property ((tx_byte_valid && tx_cfg_r.gstuff && !tx_cfg_r.rbs_en && // [R11]
    tx_byte_in == TFC_ZERO_BYTE) |=> tx_byte_r[TFC_STUFF_BIT])
    else $error("all-zero byte not stuffed");
  AST_BLUE: assert property ((line_tick && tx_cfg_r.blue) |=> (line_out_positive != line_out_negative)) // [R12]
    else $error("blue alarm mark missing on line");

  COV_BLUE: cover property (tx_byte_valid && tx_cfg_r.blue);
  COV_DOUBLE: cover property (sync_start && rx_cfg_r.double_width && rx_signaling_frame);
  COV_MW: cover property (rx_cfg_r.code_choice && rx_byte_tick);
  COV_CRC_PASS: cover property (tx_fbit_valid && tx_fbit_is_crc && tx_cfg_r.crc_pass);

endmodule // tfc_ctrl

// ==== testbench/tfc_line_model.sv ====
// far side model: receive and transmit frame timing from the line and backplane
module tfc_line_model #(
  parameter int TICK = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      rx_bit_tick,
  output logic      rx_byte_tick,
  output logic      rx_frame_start,
  output logic      rx_multiframe_start,
  output logic      rx_signaling_frame,
  output logic      tx_frame_start
);
  timeunit 1ns;
  timeprecision 1ns;
  // frame shortened to 8 bits, 4 frames a multiframe, to keep runs short
  int cyc  = 0;
  int bitn = 7;
  int frm  = 3;
  always @(posedge clk) begin
    #1;
    if (rst) begin
      cyc = 0;
      bitn = 7;
      frm = 3;
    end else begin
      cyc = (cyc + 1) % TICK;
    end
    rx_bit_tick = !rst && cyc == 0;
    if (rx_bit_tick) begin
      bitn = (bitn + 1) % 8;
      if (bitn == 0) begin
        frm = (frm + 1) % 4;
      end
    end
    // strobes only ever appear together with a bit tick
    rx_frame_start = rx_bit_tick && bitn == 0;
    rx_multiframe_start = rx_frame_start && frm == 0;
    rx_byte_tick = rx_bit_tick && bitn % 4 == 0;
    rx_signaling_frame = frm % 2 == 1;
    tx_frame_start = rx_frame_start;
  end
endmodule // tfc_line_model

// ==== testbench/tfc_ctrl_tb_top.sv ====
// self-checking bench for the framer control register pair
module tfc_ctrl_tb_top
  import tfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;
  logic clk = 1'b0, rst = 1'b1, host_wr_en = 1'b0, host_rd_en = 1'b0;
  logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, tx_byte_in = 8'h00;
  logic rx_elastic_store_enable = 1'b0, ft_error = 1'b0, fs_error = 1'b0, receive_sync_pin_in = 1'b0;
  logic tx_byte_valid = 1'b0, tx_chan_transparent = 1'b0, tx_chan_stuff = 1'b0, tx_signaling_frame = 1'b0;
  logic tx_signaling_bit = 1'b0, tx_fbit_valid = 1'b0, tx_fbit_is_crc = 1'b0, tx_fbit_internal = 1'b0;
  logic tx_crc_internal = 1'b0, tx_serial_data_in = 1'b0, line_tick = 1'b0, line_pos_in = 1'b0;
  logic line_neg_in = 1'b0;
  logic rx_bit_tick, rx_byte_tick, rx_frame_start, rx_multiframe_start, rx_signaling_frame, tx_frame_start;
  logic [7:0] host_rdata, receive_code_choice_byte, tx_byte_out;
  logic receive_sync_pulse, receive_sync_pulse_oe_n, receive_sync_from_pin, path_violation_counter_inc;
  logic tx_fbit_out, line_out_positive, line_out_negative;
  int err_count = 0;
  int comparisons = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  tfc_line_model #(.TICK(TICK)) far (.clk(clk), .rst(rst), .rx_bit_tick(rx_bit_tick),
    .rx_byte_tick(rx_byte_tick), .rx_frame_start(rx_frame_start), .rx_multiframe_start(rx_multiframe_start),
    .rx_signaling_frame(rx_signaling_frame), .tx_frame_start(tx_frame_start));

  tfc_ctrl #(.ADDR_W(8)) uut (.clk(clk), .rst(rst), .host_wr_en(host_wr_en), .host_rd_en(host_rd_en),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .rx_bit_tick(rx_bit_tick),
    .rx_byte_tick(rx_byte_tick), .rx_frame_start(rx_frame_start), .rx_multiframe_start(rx_multiframe_start),
    .rx_signaling_frame(rx_signaling_frame), .rx_elastic_store_enable(rx_elastic_store_enable),
    .ft_error(ft_error), .fs_error(fs_error), .receive_sync_pin_in(receive_sync_pin_in),
    .receive_sync_pulse(receive_sync_pulse), .receive_sync_pulse_oe_n(receive_sync_pulse_oe_n),
    .receive_sync_from_pin(receive_sync_from_pin), .receive_code_choice_byte(receive_code_choice_byte),
    .path_violation_counter_inc(path_violation_counter_inc), .tx_frame_start(tx_frame_start),
    .tx_byte_valid(tx_byte_valid), .tx_byte_in(tx_byte_in), .tx_chan_transparent(tx_chan_transparent),
    .tx_chan_stuff(tx_chan_stuff), .tx_signaling_frame(tx_signaling_frame),
    .tx_signaling_bit(tx_signaling_bit), .tx_fbit_valid(tx_fbit_valid), .tx_fbit_is_crc(tx_fbit_is_crc),
    .tx_fbit_internal(tx_fbit_internal), .tx_crc_internal(tx_crc_internal),
    .tx_serial_data_in(tx_serial_data_in), .line_tick(line_tick), .line_pos_in(line_pos_in),
    .line_neg_in(line_neg_in), .tx_byte_out(tx_byte_out), .tx_fbit_out(tx_fbit_out),
    .line_out_positive(line_out_positive), .line_out_negative(line_out_negative));

  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    host_wr_en = 1'b1;
    host_addr = a;
    host_wdata = d;
    step(1);
    host_wr_en = 1'b0;
  endtask

  task automatic host_rd(input logic [7:0] a, output logic [7:0] d);
    host_rd_en = 1'b1;
    host_addr = a;
    step(1);
    host_rd_en = 1'b0;
    d = host_rdata;
    step(1);
  endtask

  // mf/sg below zero mean either kind of boundary; mf of -2 waits for a byte
  task automatic wait_frame(input int mf, input int sg);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      if (rx_bit_tick && (mf == -2 ? rx_byte_tick : rx_frame_start) && (mf < 0 || rx_multiframe_start == mf)
          && (sg < 0 || rx_signaling_frame == sg)) begin
        #1;
        return;
      end
    end
    err_count++;
    report_and_stop();
  endtask

  // settings only take hold at a frame boundary, so wait one out
  task automatic set_reg(input logic [7:0] a, input logic [7:0] v);
    host_wr(a, v);
    wait_frame(-1, -1);
    step(1);
  endtask

  task automatic sync_width(input int exp);
    int w;
    w = 0;
    while (receive_sync_pulse === 1'b1 && w < 20) begin
      w++;
      step(1);
    end
    chk("sync pulse width", exp[7:0], w[7:0]);
  endtask

  task automatic sc_regs();
    logic [7:0] d;
    chk("idle code at reset", TFC_IDLE_CODE, receive_code_choice_byte);
    chk("sync oe_n at reset", 8'h00, {7'h00, receive_sync_pulse_oe_n});
    host_rd(TFC_RX_CTRL_OFS, d);
    chk("rx ctrl reset", TFC_RX_CTRL_RST, d);
    host_rd(TFC_TX_CTRL_OFS, d);
    chk("tx ctrl reset", TFC_TX_CTRL_RST, d);
    host_wr(TFC_RX_CTRL_OFS, 8'hA5);
    host_wr(8'h2D, 8'h33);
    host_rd(8'h2D, d);
    chk("unmapped read", TFC_UNMAPPED_READ, d);
    host_wr(TFC_TX_CTRL_OFS, 8'h5A);
    host_rd(TFC_TX_CTRL_OFS, d);
    chk("tx ctrl readback", 8'h5A, d);
    host_rd(TFC_RX_CTRL_OFS, d);
    chk("rx ctrl readback", 8'hA5, d);
  endtask

  task automatic sc_code();
    set_reg(TFC_RX_CTRL_OFS, 8'h00);
    chk("idle code", TFC_IDLE_CODE, receive_code_choice_byte);
    set_reg(TFC_RX_CTRL_OFS, 8'h80);
    // nine bytes so the wrap back to the first value is seen
    for (int i = 0; i < 9; i++) begin
      wait_frame(-2, -2);
      chk("milliwatt byte", TFC_MW_SEQ[i % TFC_MW_LEN], receive_code_choice_byte);
    end
    set_reg(TFC_RX_CTRL_OFS, 8'h00);
    chk("idle code again", TFC_IDLE_CODE, receive_code_choice_byte);
  endtask

  task automatic sc_sync();
    wait_frame(-1, 1);
    sync_width(TICK);
    set_reg(TFC_RX_CTRL_OFS, 8'h20);
    wait_frame(-1, 1);
    sync_width(2 * TICK);
    wait_frame(-1, 0);
    sync_width(TICK);
    set_reg(TFC_RX_CTRL_OFS, 8'h10);
    wait_frame(0, -1);
    chk("no sync on plain frame", 8'h00, {7'h00, receive_sync_pulse});
    wait_frame(1, -1);
    sync_width(TICK);
  endtask

  task automatic err_pulse(input logic ft, input logic fs, input logic exp);
    step(1);
    ft_error = ft;
    fs_error = fs;
    step(1);
    ft_error = 1'b0;
    fs_error = 1'b0;
    chk("violation pulse", {7'h00, exp}, {7'h00, path_violation_counter_inc});
  endtask

  task automatic sc_pins();
    rx_elastic_store_enable = 1'b1;
    set_reg(TFC_RX_CTRL_OFS, 8'h08);
    step(2);
    chk("sync pin released", 8'h01, {7'h00, receive_sync_pulse_oe_n});
    receive_sync_pin_in = 1'b1;
    step(3);
    chk("sync pin sampled", 8'h01, {7'h00, receive_sync_from_pin});
    set_reg(TFC_RX_CTRL_OFS, 8'h00);
    step(2);
    chk("sync pin driven", 8'h00, {7'h00, receive_sync_pulse_oe_n});
    err_pulse(1'b1, 1'b0, 1'b1);
    err_pulse(1'b0, 1'b1, 1'b0);
    set_reg(TFC_RX_CTRL_OFS, 8'h02);
    err_pulse(1'b0, 1'b1, 1'b1);
  endtask

  task automatic txb(input logic [7:0] d, input logic tr, st, sf, sb, input logic [7:0] exp);
    step(1);
    {tx_byte_in, tx_chan_transparent, tx_chan_stuff, tx_signaling_frame, tx_signaling_bit} = {d, tr, st, sf, sb};
    tx_byte_valid = 1'b1;
    step(1);
    tx_byte_valid = 1'b0;
    chk("tx byte", exp, tx_byte_out);
  endtask

  // serial input goes through a two-flop sync, so it is set well ahead
  task automatic fb(input logic crc, intl, crci, ser, exp);
    step(1);
    {tx_fbit_is_crc, tx_fbit_internal, tx_crc_internal, tx_serial_data_in} = {crc, intl, crci, ser};
    step(3);
    tx_fbit_valid = 1'b1;
    step(1);
    tx_fbit_valid = 1'b0;
    chk("f bit", {7'h00, exp}, {7'h00, tx_fbit_out});
  endtask

  task automatic ln(input logic p, n, input logic [1:0] exp);
    step(1);
    {line_pos_in, line_neg_in, line_tick} = {p, n, 1'b1};
    step(1);
    line_tick = 1'b0;
    chk("line pair", {6'h00, exp}, {6'h00, line_out_positive, line_out_negative});
  endtask

  task automatic sc_tx();
    set_reg(TFC_TX_CTRL_OFS, 8'h00);
    txb(8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 8'h02);
    txb(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    fb(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    fb(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    set_reg(TFC_TX_CTRL_OFS, 8'h10);
    txb(8'h40, 1'b0, 1'b0, 1'b1, 1'b1, 8'h41);
    txb(8'h40, 1'b1, 1'b0, 1'b1, 1'b1, 8'h40);
    txb(8'h40, 1'b0, 1'b0, 1'b0, 1'b1, 8'h40);
    set_reg(TFC_TX_CTRL_OFS, 8'h08);
    txb(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h02);
    txb(8'h80, 1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
    set_reg(TFC_TX_CTRL_OFS, 8'h60);
    fb(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    fb(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    set_reg(TFC_TX_CTRL_OFS, 8'h02);
    txb(8'h12, 1'b0, 1'b0, 1'b0, 1'b0, 8'hFF);
    fb(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    ln(1'b0, 1'b0, 2'b10);
    ln(1'b0, 1'b0, 2'b01);
    set_reg(TFC_TX_CTRL_OFS, 8'h00);
    ln(1'b0, 1'b1, 2'b01);
    ln(1'b1, 1'b1, 2'b11);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    sc_regs();
    sc_code();
    sc_sync();
    sc_pins();
    sc_tx();
    report_and_stop();
  end
endmodule // tfc_ctrl_tb_top
